// >>> design/daisy_chain_adc_readout.sv
// chained serial readout of an 18-bit converter, with sample fifo
`default_nettype none
`include "daisy_consts.svh"

// ==========================================================
// sample fifo
module sample_fifo #(
	parameter int WIDTH = `SAMPLE_BITS,
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int PTR_W = `FIFO_PTR_W
) (
	input  wire logic             clk,      // core clock
	input  wire logic             rst,      // sync reset, high
	input  wire logic [WIDTH-1:0] wr_data,  // incoming word
	input  wire logic             wr_valid, // incoming word valid
	output logic                  wr_ready, // room for a word
	output logic      [WIDTH-1:0] rd_data,  // head word
	output logic                  rd_valid, // head word valid
	input  wire logic             rd_ready  // drain accepts head
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0]   count_q;
	logic             push;
	logic             pop;

	assign wr_ready = (count_q != (PTR_W+1)'(DEPTH));
	assign rd_valid = (count_q != '0);
	assign rd_data  = mem_q[rd_ptr_q];
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			case ({push, pop})
				2'b10:   count_q <= count_q + 1'b1;
				2'b01:   count_q <= count_q - 1'b1;
				default: count_q <= count_q;
			endcase
		end
	end
endmodule // sample_fifo

// Summary of operation
// - strobe rising with chain input low selects chain mode, high selects chip-select.
// - chain input and strobe both low: serial output driven low.
// - shift clock low at strobe rise: chain conversion without busy indicator.
// - shift clock high at strobe rise: chain conversion with busy indicator.
// - no busy: msb appears on output when conversion completes.
// - no busy: remaining stored bits leave on successive shift clock falling edges.
// - chain input shifts into the register on each shift clock falling edge, except the first one with busy indicator.
// - own result leaves msb first, ahead of data shifted in from upstream.
// - with busy: output goes high once conversion has finished, data ready.
// - with busy: after the ready bit, stored bits shift out msb first.
// - output holds across shift clock rising edges, changing only on falling edges.
module daisy_chain_adc_readout (
	input  wire logic                  clk,               // core clock, 40 mhz
	input  wire logic                  rst,               // sync reset, high
	input  wire logic                  sck,               // host shift clock
	input  wire logic                  convert_strobe,    // conversion strobe pin
	input  wire logic                  chain_serial_in,   // upstream chain data
	output logic                       result_serial_out, // serial data out
	output logic                       result_serial_oe,  // serial output drive enable
	input  wire logic [`SAMPLE_MSB:0]  sample_data,       // converted sample word
	input  wire logic                  sample_valid,      // sample word valid
	output logic                       sample_ready,      // fifo has room
	output logic                       converting         // conversion in progress
);
	localparam int CONV_C = `CONV_CYCLES;

	// ==========================================================
	// pin synchronisers
	logic [1:0] cnv_sync_q;
	logic [1:0] sdi_sync_q;
	logic [1:0] sck_sync_q;
	logic       cnv_prev_q;
	logic       cnv_rise;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnv_sync_q <= 2'h0;
			sdi_sync_q <= 2'h0;
			sck_sync_q <= 2'h0;
			cnv_prev_q <= 1'b0;
		end else begin
			cnv_sync_q <= {cnv_sync_q[0], convert_strobe};
			sdi_sync_q <= {sdi_sync_q[0], chain_serial_in};
			sck_sync_q <= {sck_sync_q[0], sck};
			cnv_prev_q <= cnv_sync_q[1];
		end
	end

	// strobe edge seen two cycles late; chain input and shift clock must hold that long
	assign cnv_rise = cnv_sync_q[1] && !cnv_prev_q;

	// ==========================================================
	// sample buffer
	logic [`SAMPLE_MSB:0] head_data;
	logic                 head_valid;
	logic                 head_take;

	sample_fifo #(
		.WIDTH (`SAMPLE_BITS),
		.DEPTH (`FIFO_DEPTH),
		.PTR_W (`FIFO_PTR_W)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.wr_data  (sample_data),
		.wr_valid (sample_valid),
		.wr_ready (sample_ready),
		.rd_data  (head_data),
		.rd_valid (head_valid),
		.rd_ready (head_take)
	);

	// ==========================================================
	// conversion control
	daisy_pkg::conv_state_type state_q;
	daisy_pkg::frame_mode_type mode_q;
	logic [`CONV_CNT_W-1:0]    conv_cnt_q;
	logic [`SAMPLE_MSB:0]      word_q;
	logic                      conv_end;

	// an empty fifo stretches the conversion until a word arrives
	assign conv_end  = (state_q == daisy_pkg::st_convert) &&
	                   (conv_cnt_q == `CONV_CNT_W'(CONV_C - 1));
	assign head_take = conv_end && head_valid;
	assign converting = (state_q == daisy_pkg::st_convert);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= daisy_pkg::st_idle;
		end else begin
			case (state_q)
				daisy_pkg::st_idle: begin
					if (cnv_rise && !sdi_sync_q[1]) begin
						state_q <= daisy_pkg::st_convert;
					end
				end
				daisy_pkg::st_convert: begin
					if (head_take) begin
						state_q <= daisy_pkg::st_ready;
					end
				end
				daisy_pkg::st_ready: begin
					if (!cnv_sync_q[1]) begin
						state_q <= daisy_pkg::st_idle;
					end
				end
				default: state_q <= daisy_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= '0;
		end else if (cnv_rise) begin
			mode_q.chain   <= !sdi_sync_q[1];
			mode_q.busy_en <= sck_sync_q[1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			conv_cnt_q <= '0;
		end else if (state_q != daisy_pkg::st_convert) begin
			conv_cnt_q <= '0;
		end else if (!conv_end) begin
			conv_cnt_q <= conv_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			word_q <= '0;
		end else if (head_take) begin
			word_q <= head_data;
		end
	end

	// ==========================================================
	// link side, on the shift clock
	// word_q and mode_q stay still for the whole readback, so the link reads them directly
	logic [`BIT_CNT_W-1:0] bit_cnt_q;
	logic [`SAMPLE_MSB:0]  hist_q;

	// strobe low ends the frame, since the shift clock stops outside it
	always_ff @(negedge sck or negedge convert_strobe) begin
		if (!convert_strobe) begin
			bit_cnt_q <= '0;
			hist_q    <= '0;
		end else begin
			if (bit_cnt_q != `BIT_CNT_MAX) begin
				bit_cnt_q <= bit_cnt_q + 1'b1;
			end
			// chain shift, skipping the start-bit slot
			if (!(mode_q.busy_en && bit_cnt_q == '0)) begin
				hist_q <= {hist_q[`SAMPLE_MSB-1:0], chain_serial_in};
			end
		end
	end

	// ==========================================================
	// serial output
	logic [`BIT_CNT_W-1:0] bit_idx;
	logic [`BIT_CNT_W-1:0] bit_sel;
	logic                  data_bit;

	assign bit_idx = mode_q.busy_en ? bit_cnt_q - 1'b1 : bit_cnt_q;
	assign bit_sel = `BIT_CNT_W'(`SAMPLE_MSB) - bit_idx;

	always_comb begin
		data_bit = 1'b0;
		if (mode_q.busy_en && bit_cnt_q == '0) begin
			data_bit = 1'b1;
		end else if (bit_idx < `BIT_CNT_W'(`SAMPLE_BITS)) begin
			data_bit = word_q[bit_sel];
		end else begin
			data_bit = hist_q[`SAMPLE_MSB];
		end
	end

	always_comb begin
		result_serial_out = 1'b0;
		result_serial_oe  = 1'b0;
		if (!convert_strobe && !chain_serial_in) begin
			result_serial_oe = 1'b1;
		end else if (convert_strobe && state_q == daisy_pkg::st_convert) begin
			result_serial_oe = 1'b1;
		end else if (convert_strobe && state_q == daisy_pkg::st_ready) begin
			result_serial_oe  = 1'b1;
			result_serial_out = data_bit;
		end
	end

	// ==========================================================
	// checks
	a_idle_low: assert property (@(posedge clk) disable iff (rst)
		(!convert_strobe && !chain_serial_in) |-> (result_serial_oe && !result_serial_out))
		else $error("output not driven low while strobe and chain input low");

	a_chain_pick: assert property (@(posedge clk) disable iff (rst)
		(cnv_rise && state_q == daisy_pkg::st_idle) |=> (mode_q.chain == !$past(sdi_sync_q[1]) &&
		(state_q == daisy_pkg::st_convert) == mode_q.chain))
		else $error("mode not picked from chain input");

	a_busy_off: assert property (@(posedge clk) disable iff (rst)
		(cnv_rise && !sdi_sync_q[1] && !sck_sync_q[1]) |=> !mode_q.busy_en)
		else $error("busy indicator enabled with shift clock low");

	a_busy_on: assert property (@(posedge clk) disable iff (rst)
		(cnv_rise && !sdi_sync_q[1] && sck_sync_q[1]) |=> mode_q.busy_en)
		else $error("busy indicator not enabled with shift clock high");

	a_conv_time: assert property (@(posedge clk) disable iff (rst)
		($rose(converting) && head_valid && convert_strobe) |-> ##[CONV_C:CONV_C] $rose(state_q == daisy_pkg::st_ready))
		else $error("conversion length wrong");

	a_word_load: assert property (@(posedge clk) disable iff (rst)
		$rose(state_q == daisy_pkg::st_ready) |-> (word_q == $past(head_data)))
		else $error("result not loaded at end of conversion");

	a_msb_first: assert property (@(posedge clk) disable iff (rst)
		($rose(state_q == daisy_pkg::st_ready) && !mode_q.busy_en && convert_strobe && bit_cnt_q == '0)
		|-> (result_serial_oe && result_serial_out == word_q[`SAMPLE_MSB]))
		else $error("msb not presented at end of conversion");

	a_ready_high: assert property (@(posedge clk) disable iff (rst)
		($rose(state_q == daisy_pkg::st_ready) && mode_q.busy_en && convert_strobe && bit_cnt_q == '0)
		|-> (result_serial_oe && result_serial_out))
		else $error("ready bit not driven high");

	a_shift_in: assert property (@(negedge sck) disable iff (!convert_strobe)
		!(mode_q.busy_en && bit_cnt_q == '0) |=> (hist_q[0] == $past(chain_serial_in)))
		else $error("chain input not shifted in");

	a_bit_order: assert property (@(negedge sck) disable iff (!convert_strobe)
		(state_q == daisy_pkg::st_ready && !mode_q.busy_en && bit_cnt_q < 5'h11)
		|=> (result_serial_out == word_q[5'h10 - $past(bit_cnt_q)]))
		else $error("stored bit out of order");

	a_upstream_after: assert property (@(negedge sck) disable iff (!convert_strobe)
		(state_q == daisy_pkg::st_ready && !mode_q.busy_en && bit_cnt_q == 5'h11)
		|=> (result_serial_out == $past(chain_serial_in, 18)))
		else $error("upstream data not after own result");

	c_chain_plain: cover property (@(posedge clk) disable iff (rst)
		$rose(state_q == daisy_pkg::st_ready) && !mode_q.busy_en);
	c_chain_busy: cover property (@(posedge clk) disable iff (rst)
		$rose(state_q == daisy_pkg::st_ready) && mode_q.busy_en);
	c_cs_pick: cover property (@(posedge clk) disable iff (rst)
		cnv_rise && sdi_sync_q[1]);
	c_fifo_full: cover property (@(posedge clk) disable iff (rst)
		sample_valid && !sample_ready);
endmodule // daisy_chain_adc_readout
`default_nettype wire

// >>> design/daisy_consts.svh
// constants for the chained converter readout
`ifndef DAISY_CONSTS_SVH
`define DAISY_CONSTS_SVH
`define SAMPLE_BITS     18
`define SAMPLE_MSB      17
`define CLK_PERIOD_NS   25
`define CONV_TIME_NS    2000
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W      7
`define FIFO_DEPTH      4
`define FIFO_PTR_W      2
`define BIT_CNT_W       5
`define BIT_CNT_MAX     5'h13
`endif

// >>> design/daisy_pkg.sv
// types shared by the chained converter readout
`default_nettype none
package daisy_pkg;
	typedef enum logic [2:0] {
		st_idle    = 3'b001,
		st_convert = 3'b010,
		st_ready   = 3'b100
	} conv_state_type;

	typedef struct packed {
		logic chain;
		logic busy_en;
	} frame_mode_type;
endpackage
`default_nettype wire

// >>> testbench/upstream_converter.sv
// model of the upstream converter that feeds the chain input
`default_nettype none
module upstream_converter (
	input  wire logic        sck,            // host shift clock
	input  wire logic        convert_strobe, // shared conversion strobe
	input  wire logic        load,           // own result ready, pulse
	input  wire logic        busy_en,        // busy indicator mode
	input  wire logic [17:0] word,           // own conversion result
	output logic             serial_out      // feeds the chain input
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// shift path
	logic [18:0] shift_q;
	initial shift_q = 19'h00000;
	always @(posedge load or negedge sck) begin
		if (load) shift_q <= busy_en ? {1'h1, word} : {word, 1'h0};
		else shift_q <= {shift_q[17:0], 1'h0};
	end
	assign serial_out = convert_strobe ? shift_q[18] : 1'h0;
endmodule // upstream_converter
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the chained converter readout
`default_nettype none
`include "daisy_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk, rst, sck, convert_strobe, cs_sel, load, busy_en;
	logic                 chain_in, up_out, serial_out, serial_oe, sample_valid, sample_ready, converting;
	logic [`SAMPLE_MSB:0] sample_data, up_word, w0;
	logic [31:0]          lfsr;
	logic [`SAMPLE_MSB:0] exp_q[$];
	int                   n_mismatch, check_count, i;

	// forcing the chain input high selects the chip-select path
	assign chain_in = cs_sel ? 1'h1 : up_out;
	daisy_chain_adc_readout dut (.clk(clk), .rst(rst), .sck(sck), .convert_strobe(convert_strobe),
		.chain_serial_in(chain_in), .result_serial_out(serial_out), .result_serial_oe(serial_oe),
		.sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.converting(converting));
	upstream_converter up (.sck(sck), .convert_strobe(convert_strobe), .load(load), .busy_en(busy_en),
		.word(up_word), .serial_out(up_out));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	// bit on the line after j falling edges
	function automatic logic exp_bit(input logic busy, input logic [17:0] w, input logic [17:0] u, input int j);
		logic [36:0] s;
		s = busy ? {1'h1, w, u} : {w, u, 1'h0};
		return s[36-j];
	endfunction

	task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic push(input logic [17:0] w, input logic last);
		int k;
		sample_data  <= w;
		sample_valid <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (sample_ready === 1'h1) break;
		end
		if (k == 50) begin
			n_mismatch++;
			wrap_up();
		end
		exp_q.push_back(w);
		if (last) sample_valid <= 1'h0;
	endtask

	task automatic wait_conv(input logic v, input int bound);
		int k;
		for (k = 0; k < bound; k++) begin
			@(posedge clk);
			if (converting === v) break;
		end
		if (k == bound) begin
			n_mismatch++;
			wrap_up();
		end
	endtask

	task automatic frame(input logic busy);
		logic [17:0] w;
		int          j;
		sck     <= busy;
		busy_en <= busy;
		repeat (8) @(posedge clk);
		convert_strobe <= 1'h1;
		wait_conv(1'h1, 10);
		if (exp_q.size() == 0) begin
			repeat (120) @(posedge clk);
			check("stalled", converting, 1'h1);
			lfsr = lfsr_next(lfsr);
			push(lfsr[17:0], 1'h1);
		end
		w = exp_q.pop_front();
		wait_conv(1'h0, 300);
		lfsr = lfsr_next(lfsr);
		up_word <= lfsr[31:14];
		load    <= 1'h1;
		@(posedge clk);
		load <= 1'h0;
		@(posedge clk);
		check("ready oe", serial_oe, 1'h1);
		check("first bit", serial_out, exp_bit(busy, w, up_word, 0));
		// odd offset keeps the link clock out of phase with clk
		#3.3;
		if (!busy) #16 sck = 1'h1;
		for (j = 1; j <= 36 + busy; j++) begin
			#15;
			check("held bit", serial_out, exp_bit(busy, w, up_word, j - 1));
			#1 sck = 1'h0;
			#16 sck = 1'h1;
			if (j < 36 + busy) check("serial bit", serial_out, exp_bit(busy, w, up_word, j));
		end
		@(posedge clk);
		convert_strobe <= 1'h0;
		repeat (8) @(posedge clk);
		check("idle line", {serial_oe, serial_out}, 2'h2);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst            = 1'h1;
		sck            = 1'h0;
		convert_strobe = 1'h0;
		cs_sel         = 1'h0;
		load           = 1'h0;
		busy_en        = 1'h0;
		sample_valid   = 1'h0;
		sample_data    = 18'h00000;
		up_word        = 18'h00000;
		lfsr           = 32'h10c4;
		n_mismatch     = 0;
		check_count    = 0;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		check("reset state", {serial_oe, serial_out, sample_ready, converting}, 4'ha);
		cs_sel <= 1'h1;
		repeat (8) @(posedge clk);
		check("cs idle oe", serial_oe, 1'h0);
		convert_strobe <= 1'h1;
		repeat (20) @(posedge clk);
		check("cs mode", {serial_oe, converting}, 2'h0);
		convert_strobe <= 1'h0;
		cs_sel         <= 1'h0;
		repeat (8) @(posedge clk);
		// corner words first, then random ones, back to back
		for (i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			w0   = (i == 0) ? 18'h20000 : (i == 1) ? 18'h1ffff : lfsr[17:0];
			push(w0, i == 3);
		end
		@(posedge clk);
		check("fifo full", sample_ready, 1'h0);
		// a word offered while full must not be taken
		sample_data  <= 18'h15555;
		sample_valid <= 1'h1;
		repeat (4) @(posedge clk);
		sample_valid <= 1'h0;
		for (i = 0; i < 6; i++) frame(i[0]);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
